// ---- include/mcb_pkg.sv ----
// What this block does
// [RULE1] Soft mute set: attenuator steps down 0.5dB at a time to infinite.
// [RULE2] Soft mute cleared: attenuator steps back up to the programmed level.
// [RULE3] Output disable bit routes amplifier input to common-mode level; reset 0.
// [RULE4] Roll-off bit: 0 sharp (reset), 1 slow.
// [RULE5] Clock-out half-rate bit: 0 full rate (reset), 1 half rate.
// [RULE6] Clock-out disable bit: 0 drives clock, 1 holds pin low.
// [RULE7] Three-bit format field selects audio format; reset 000.
// [RULE8] De-emphasis rate field: 00 44.1k, 01 48k, 10 32k, 11 reserved.
// [RULE9] De-emphasis enable bit turns de-emphasis on for all channels together.
// [RULE10] Phase bit: 0 normal, 1 inverted output polarity.
// [RULE11] Zero-flag polarity: 0 high on zero, 1 low on zero.
// [RULE12] Auto-increment bit enables auto-increment reads; 0 single reads only.
// [RULE13] Read index names the register a single read returns; reset 01h.
// [RULE14] In auto-increment reads the read index is the last register returned.
// [RULE15] Aux output enable 1 drives the six aux bits onto the shared pins.
// [RULE16] Aux output enable 0 puts zero flags on the shared pins.
// [RULE17] Oversampling bit at high clock ratios: 0 gives 64x, 1 gives 128x.
// [RULE18] Oversampling bit at 128/192 ratios: 0 gives 32x, 1 gives 64x.
// [RULE19] Host should set oversampling bit at 192kHz with low clock ratios.
// [RULE20] Word bit 15 selects direction: 0 write, 1 read.
// [RULE21] Attenuator moves one 0.5dB step every eight sample periods.
// [RULE22] Codes 0 to 128 are infinite attenuation; soft mute ramps there.
// [RULE23] Zero condition after 1024 consecutive zero samples, per channel.
// [RULE24] Bits 14:8 select target register; reserved bits written as zero.
package mcb_pkg;
    localparam int NCH = 6;
    localparam logic [6:0] IDX_ATT_FIRST = 7'h01;
    localparam logic [6:0] IDX_ATT_LAST = 7'h06;
    localparam logic [6:0] IDX_MUTE = 7'h07;
    localparam logic [6:0] IDX_OUTSW = 7'h08;
    localparam logic [6:0] IDX_FCF = 7'h09;
    localparam logic [6:0] IDX_DEP = 7'h0A;
    localparam logic [6:0] IDX_RDB = 7'h0B;
    localparam logic [6:0] IDX_AUX = 7'h0C;
    localparam int WORD_RW_BIT = 15;
    localparam int WORD_IDX_LSB = 8;
    localparam logic [7:0] ATT_RESET = 8'hFF;
    localparam logic [7:0] ATT_MUTE_CODE = 8'h80;
    localparam logic [6:0] READ_INDEX_RESET = 7'h01;
    localparam int STEP_SAMPLES = 8;
    localparam int ZERO_SAMPLES = 1024;
    localparam logic [2:0] STEP_CNT_MAX = 3'h7;
    localparam logic [10:0] ZERO_CNT_MAX = 11'h400;
    // Field positions within data byte.
    localparam int FCF_FMT_LSB = 0;
    localparam int FCF_CLKOFF = 3;
    localparam int FCF_HALF = 4;
    localparam int FCF_ROLL = 5;
    localparam int DEP_EN = 0;
    localparam int DEP_RATE_LSB = 3;
    localparam int DEP_PHASE = 5;
    localparam int DEP_ZPOL = 6;
    localparam int RDB_INC = 7;
    localparam int AUX_EN = 6;
    localparam int AUX_OVER = 7;
endpackage

// ---- src/mcb_att_ramp.sv ----
`timescale 1ns/100ps
// One channel's attenuator ramp and zero detector.
module mcb_att_ramp (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic step_en, // One pulse per eight sample periods.
    input wire logic sample_en, // One pulse per sample period.
    input wire logic [7:0] target, // Programmed attenuation level.
    input wire logic mute, // Soft mute request.
    input wire logic data_zero, // Channel sample is zero this period.
    output logic [7:0] level, // Present attenuator level.
    output logic zero // Zero condition detected.
);
    typedef struct packed {
        logic [7:0] level;
        logic [10:0] zcnt;
        logic zero;
    } mcb_ramp_s;
    mcb_ramp_s r, next_r;
    logic [7:0] goal;

    always_comb begin
        next_r = r;
        // Anything at or below the mute code is already infinite attenuation.
        goal = (mute || target <= mcb_pkg::ATT_MUTE_CODE) ? mcb_pkg::ATT_MUTE_CODE : target; // [RULE22]
        if (r.level < mcb_pkg::ATT_MUTE_CODE) begin
            next_r.level = mcb_pkg::ATT_MUTE_CODE;
        end else if (step_en) begin
            if (r.level > goal) begin
                next_r.level = r.level - 8'h01; // [RULE1] [RULE21]
            end else if (r.level < goal) begin
                next_r.level = r.level + 8'h01; // [RULE2] [RULE21]
            end
        end
        if (sample_en) begin
            if (!data_zero) begin
                next_r.zcnt = 11'h000;
            end else if (r.zcnt != mcb_pkg::ZERO_CNT_MAX) begin
                next_r.zcnt = r.zcnt + 11'h001;
            end
        end
        next_r.zero = (next_r.zcnt == mcb_pkg::ZERO_CNT_MAX); // [RULE23]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{level: mcb_pkg::ATT_RESET, zcnt: 11'h000, zero: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;
    assign zero = r.zero;

    a_ramp_step: assert property (@(posedge clk) disable iff (rst)
        !step_en && r.level >= mcb_pkg::ATT_MUTE_CODE |=> $stable(r.level)) // [RULE21]
        else $error("Attenuator moved without a step pulse.");
    a_mute_down: assert property (@(posedge clk) disable iff (rst)
        step_en && mute && r.level > mcb_pkg::ATT_MUTE_CODE |=> r.level == $past(r.level) - 8'h01) // [RULE1]
        else $error("Soft mute did not step down by one.");
    a_zero_clear: assert property (@(posedge clk) disable iff (rst)
        sample_en && !data_zero |=> !r.zero) // [RULE23]
        else $error("Zero flag held after nonzero data.");
endmodule

// ---- src/mcb_mode_ctrl.sv ----
`timescale 1ns/100ps
// Mode-control register bank. Words arrive already deserialised from the
// control port; read data is returned as a word per request.
module mcb_mode_ctrl (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic word_valid, // One-cycle strobe: a 16-bit control word.
    input wire logic [15:0] word_in, // Control word: direction, index, data.
    input wire logic rd_next, // One-cycle strobe: next word of a read sequence.
    input wire logic sample_tick, // Sample-rate tick; its rising edge marks each period.
    input wire logic [5:0] data_zero, // Per-channel zero sample this period.
    input wire logic sysclk_in_pin, // Input system clock, from a pin.
    output logic rd_valid, // Read word valid, one cycle.
    output logic [15:0] rd_word, // Read word.
    output logic rd_last, // Last word of the read sequence.
    output logic [47:0] channel_attenuation_level, // Six live attenuator levels.
    output logic [5:0] channel_output_disable, // 1: amp input at common mode.
    output logic rolloff_select, // 0 sharp, 1 slow.
    output logic [2:0] audio_format_select, // Audio data format code.
    output logic [1:0] deemphasis_rate_select, // De-emphasis rate code.
    output logic deemphasis_enable_all, // De-emphasis on for all channels.
    output logic output_phase_invert, // Invert output polarity.
    output logic oversample_high, // Oversampling bit.
    output logic system_clock_out_pin, // System clock out, full/half/low.
    output logic [5:0] shared_pins, // Zero flags or aux outputs.
    output logic all_zero_flag // All channels in zero condition.
);
    typedef struct packed {
        logic [1:0] ck_sync;
        logic [1:0] ts_sync;
        logic ts_prev;
        logic ck_div;
        logic ck_out;
        logic [2:0] step_cnt;
        logic step_en;
        logic samp_en;
        logic [47:0] att;
        logic [5:0] mute;
        logic [5:0] outsw;
        logic [5:0] fcf;
        logic [6:0] dep;
        logic [7:0] rdb;
        logic [7:0] aux;
        logic [6:0] rd_ptr;
        logic rd_busy;
        logic rd_valid;
        logic [15:0] rd_word;
        logic rd_last;
        logic [5:0] pins;
        logic zall;
        logic [47:0] lvl;
        logic [5:0] outsw_q;
        logic [2:0] fmt_q;
        logic [1:0] dmf_q;
        logic roll_q;
        logic dmc_q;
        logic phase_q;
        logic over_q;
    } mcb_bank_s;
    mcb_bank_s r, next_r;

    logic [47:0] live_level;
    logic [5:0] live_zero;
    logic [5:0] zflag;

    function automatic logic [7:0] reg_read(input mcb_bank_s s, input logic [6:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx >= mcb_pkg::IDX_ATT_FIRST && idx <= mcb_pkg::IDX_ATT_LAST) begin
            v = s.att[8 * (idx - 7'h01) +: 8];
        end else begin
            case (idx)
                mcb_pkg::IDX_MUTE: v = {2'h0, s.mute};
                mcb_pkg::IDX_OUTSW: v = {2'h0, s.outsw};
                mcb_pkg::IDX_FCF: v = {2'h0, s.fcf};
                mcb_pkg::IDX_DEP: v = {1'h0, s.dep};
                mcb_pkg::IDX_RDB: v = s.rdb;
                mcb_pkg::IDX_AUX: v = s.aux;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    function automatic logic [15:0] read_word(input mcb_bank_s s, input logic [6:0] idx);
        return {1'b1, idx, reg_read(s, idx)};
    endfunction

    genvar g;
    generate
        for (g = 0; g < mcb_pkg::NCH; g++) begin : g_ch
            mcb_att_ramp u_ramp (
                .clk(clk),
                .rst(rst),
                .step_en(r.step_en),
                .sample_en(r.samp_en),
                .target(r.att[8 * g +: 8]),
                .mute(r.mute[g]),
                .data_zero(data_zero[g]),
                .level(live_level[8 * g +: 8]),
                .zero(live_zero[g])
            );
        end
    endgenerate

    always_comb begin
        logic [6:0] idx;
        logic [7:0] d;
        idx = word_in[14:8]; // [RULE24]
        d = word_in[7:0];
        next_r = r;
        next_r.ck_sync = {r.ck_sync[0], sysclk_in_pin};
        next_r.ts_sync = {r.ts_sync[0], sample_tick};
        next_r.ts_prev = r.ts_sync[1];
        next_r.samp_en = r.ts_sync[1] && !r.ts_prev;
        next_r.step_en = 1'b0;
        if (r.samp_en) begin
            next_r.step_cnt = r.step_cnt + 3'h1;
            next_r.step_en = (r.step_cnt == mcb_pkg::STEP_CNT_MAX); // [RULE21]
        end
        // The sampled input clock is divided in this domain, so the output
        // is only a faithful copy when the pin clock is well below clk/4.
        if (r.ck_sync[1] && !r.ck_div) begin
            next_r.ck_out = ~r.ck_out;
        end
        next_r.ck_div = r.ck_sync[1];
        if (r.fcf[mcb_pkg::FCF_CLKOFF]) begin
            next_r.ck_out = 1'b0; // [RULE6]
        end else if (!r.fcf[mcb_pkg::FCF_HALF]) begin
            next_r.ck_out = r.ck_sync[1]; // [RULE5]
        end
        next_r.rd_valid = 1'b0;
        next_r.rd_last = 1'b0;
        if (word_valid && !word_in[mcb_pkg::WORD_RW_BIT]) begin // [RULE20]
            if (idx >= mcb_pkg::IDX_ATT_FIRST && idx <= mcb_pkg::IDX_ATT_LAST) begin
                next_r.att[8 * (idx - 7'h01) +: 8] = d;
            end else begin
                case (idx)
                    mcb_pkg::IDX_MUTE: next_r.mute = d[5:0]; // [RULE1] [RULE2]
                    mcb_pkg::IDX_OUTSW: next_r.outsw = d[5:0]; // [RULE3]
                    mcb_pkg::IDX_FCF: next_r.fcf = d[5:0]; // [RULE4] [RULE7]
                    mcb_pkg::IDX_DEP: next_r.dep = d[6:0]; // [RULE8] [RULE9]
                    mcb_pkg::IDX_RDB: next_r.rdb = d; // [RULE12] [RULE13]
                    mcb_pkg::IDX_AUX: next_r.aux = d; // [RULE15] [RULE17]
                    default: next_r.rdb = r.rdb;
                endcase
            end
        end else if (word_valid) begin
            next_r.rd_valid = 1'b1;
            if (r.rdb[mcb_pkg::RDB_INC]) begin
                // Auto-increment walks from the first register to the index.
                next_r.rd_word = read_word(r, mcb_pkg::IDX_ATT_FIRST); // [RULE14]
                next_r.rd_ptr = mcb_pkg::IDX_ATT_FIRST;
                next_r.rd_last = (r.rdb[6:0] <= mcb_pkg::IDX_ATT_FIRST);
                next_r.rd_busy = !next_r.rd_last;
            end else begin
                next_r.rd_word = read_word(r, r.rdb[6:0]); // [RULE13]
                next_r.rd_last = 1'b1;
                next_r.rd_busy = 1'b0;
            end
        end else if (rd_next && r.rd_busy) begin
            next_r.rd_ptr = r.rd_ptr + 7'h01;
            next_r.rd_valid = 1'b1;
            next_r.rd_word = read_word(r, next_r.rd_ptr);
            next_r.rd_last = (next_r.rd_ptr >= r.rdb[6:0]); // [RULE14] [RULE12]
            next_r.rd_busy = !next_r.rd_last;
        end
        for (int i = 0; i < mcb_pkg::NCH; i++) begin
            next_r.pins[i] = r.aux[mcb_pkg::AUX_EN] ? r.aux[i] : zflag[i]; // [RULE15] [RULE16]
        end
        next_r.zall = &live_zero ^ r.dep[mcb_pkg::DEP_ZPOL]; // [RULE11]
        next_r.lvl = live_level;
        next_r.outsw_q = r.outsw;
        next_r.fmt_q = r.fcf[mcb_pkg::FCF_FMT_LSB +: 3];
        next_r.roll_q = r.fcf[mcb_pkg::FCF_ROLL];
        next_r.dmf_q = r.dep[mcb_pkg::DEP_RATE_LSB +: 2];
        next_r.dmc_q = r.dep[mcb_pkg::DEP_EN];
        next_r.phase_q = r.dep[mcb_pkg::DEP_PHASE]; // [RULE10]
        next_r.over_q = r.aux[mcb_pkg::AUX_OVER]; // [RULE17] [RULE18]
    end

    assign zflag = live_zero ^ {6{r.dep[mcb_pkg::DEP_ZPOL]}}; // [RULE11]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.att <= {6{mcb_pkg::ATT_RESET}};
            r.lvl <= {6{mcb_pkg::ATT_RESET}};
            r.rdb <= {1'b0, mcb_pkg::READ_INDEX_RESET};
        end else begin
            r <= next_r;
        end
    end

    assign rd_valid = r.rd_valid;
    assign rd_word = r.rd_word;
    assign rd_last = r.rd_last;
    assign channel_attenuation_level = r.lvl;
    assign channel_output_disable = r.outsw_q;
    assign rolloff_select = r.roll_q;
    assign audio_format_select = r.fmt_q;
    assign deemphasis_rate_select = r.dmf_q;
    assign deemphasis_enable_all = r.dmc_q;
    assign output_phase_invert = r.phase_q;
    assign oversample_high = r.over_q;
    assign system_clock_out_pin = r.ck_out;
    assign shared_pins = r.pins;
    assign all_zero_flag = r.zall;

    sequence s_write_word(logic [6:0] ix);
        word_valid && !word_in[15] && word_in[14:8] == ix;
    endsequence

    a_clk_off_low: assert property (@(posedge clk) disable iff (rst)
        r.fcf[mcb_pkg::FCF_CLKOFF] ##1 r.fcf[mcb_pkg::FCF_CLKOFF] |-> !system_clock_out_pin) // [RULE6]
        else $error("Clock out not low while disabled.");
    a_aux_drive: assert property (@(posedge clk) disable iff (rst)
        r.aux[mcb_pkg::AUX_EN] |=> shared_pins == $past(r.aux[5:0])) // [RULE15]
        else $error("Aux bits not on shared pins.");
    a_zero_route: assert property (@(posedge clk) disable iff (rst)
        !r.aux[mcb_pkg::AUX_EN] |=> shared_pins == $past(zflag)) // [RULE16]
        else $error("Zero flags not on shared pins.");
    a_write_mute: assert property (@(posedge clk) disable iff (rst)
        s_write_word(mcb_pkg::IDX_MUTE) |=> r.mute == $past(word_in[5:0])) // [RULE20]
        else $error("Mute write not stored.");
    a_read_no_write: assert property (@(posedge clk) disable iff (rst)
        word_valid && word_in[15] |=> $stable(r.fcf) && rd_valid) // [RULE20]
        else $error("Read word altered a register.");
    a_single_read: assert property (@(posedge clk) disable iff (rst)
        word_valid && word_in[15] && !r.rdb[7] |=> rd_last && rd_word[14:8] == $past(r.rdb[6:0])) // [RULE13]
        else $error("Single read returned wrong index.");
    a_inc_last: assert property (@(posedge clk) disable iff (rst)
        rd_valid && rd_last && r.rdb[7] |-> rd_word[14:8] >= r.rdb[6:0]) // [RULE14]
        else $error("Auto-increment ended early.");
    a_outsw_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_word(mcb_pkg::IDX_OUTSW) |=> ##1 channel_output_disable == $past(word_in[5:0], 2)) // [RULE3]
        else $error("Output disable not applied.");
endmodule

// ---- testbench/mcb_host.sv ----
`timescale 1ns/100ps
// Host side of the control port: sends whole control words, one per strobe.
module mcb_host (
    input wire logic clk, // System clock.
    output logic word_valid, // Word strobe.
    output logic [15:0] word_in, // Control word.
    output logic rd_next // Next-word strobe.
);
    initial begin
        word_valid = 1'b0;
        word_in = 16'h0000;
        rd_next = 1'b0;
    end
    // The word lines show a changed pattern once released, so a stale word is never reused.
    task automatic send(input logic rd, input logic [6:0] idx, input logic [7:0] d);
        @(posedge clk);
        word_valid <= 1'b1;
        word_in <= {rd, idx, d};
        @(posedge clk);
        word_valid <= 1'b0;
        word_in <= ~{rd, idx, d};
    endtask
    task automatic step_read();
        @(posedge clk);
        rd_next <= 1'b1;
        @(posedge clk);
        rd_next <= 1'b0;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic clk, rst, word_valid, rd_next, rd_valid, rd_last, rolloff_select;
    logic deemphasis_enable_all, output_phase_invert, oversample_high;
    logic system_clock_out_pin, all_zero_flag;
    logic sample_tick = 1'b0;
    logic sysclk_in_pin = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [15:0] word_in, rd_word;
    logic [47:0] channel_attenuation_level;
    logic [5:0] data_zero, channel_output_disable, shared_pins;
    logic [2:0] audio_format_select;
    logic [1:0] deemphasis_rate_select;
    logic [7:0] prev_lvl = 8'hFF;
    logic [16:0] exp_q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    int gap = 0;
    int n_steps = 0;
    integer seed = 32'hFE2BCE55;
    mcb_host host (.clk, .word_valid, .word_in, .rd_next);
    mcb_mode_ctrl dut (.clk, .rst, .word_valid, .word_in, .rd_next, .sample_tick, .data_zero,
        .sysclk_in_pin, .rd_valid, .rd_word, .rd_last, .channel_attenuation_level,
        .channel_output_disable, .rolloff_select, .audio_format_select,
        .deemphasis_rate_select, .deemphasis_enable_all, .output_phase_invert,
        .oversample_high, .system_clock_out_pin, .shared_pins, .all_zero_flag);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Sample period of 8 clocks, input system clock of 16 clocks.
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
        sample_tick <= cnt[2];
        sysclk_in_pin <= cnt[3];
    end
    task automatic chk(input string what, input logic [47:0] e_v, input logic [47:0] g_v);
        total_checks++;
        if (e_v !== g_v) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e_v, g_v);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected read", 48'h0, 48'h1);
            else
                chk("read word", exp_q.pop_front(), {rd_last, rd_word});
        end
    end
    // Every change of the channel 1 level must be one step, at least eight samples apart.
    always @(negedge clk) begin
        gap++;
        if (channel_attenuation_level[7:0] !== prev_lvl) begin
            chk("ramp step", 48'h1, 48'(channel_attenuation_level[7:0] - prev_lvl + 8'h1 <= 8'h2
                && channel_attenuation_level[7:0] != prev_lvl));
            chk("ramp spacing", 48'h1, 48'(gap >= 64));
            n_steps++;
            gap = 0;
            prev_lvl = channel_attenuation_level[7:0];
        end
    end
    task automatic wait_until(input int sel, input logic [7:0] v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((sel == 0 ? channel_attenuation_level[7:0] : {2'b00, shared_pins}) === v)
                return;
        end
        chk("wait bound", 48'h0, 48'h1);
        close_out();
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        host.send(1'b0, idx, d);
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rd1(input logic [6:0] idx, input logic [7:0] d);
        wr(mcb_pkg::IDX_RDB, {1'b0, idx});
        exp_q.push_back({1'b1, 1'b1, idx, d});
        host.send(1'b1, idx, 8'h00);
        repeat (2) @(posedge clk);
    endtask
    initial begin
        logic [7:0] d8, d9, da, dc;
        logic [31:0] r;
        int n, e;
        logic prv;
        rst = 1'b1;
        data_zero = 6'h00;
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk("reset outputs", 48'h0, {channel_output_disable, rolloff_select, audio_format_select,
            deemphasis_rate_select, deemphasis_enable_all, output_phase_invert, oversample_high,
            system_clock_out_pin, shared_pins, all_zero_flag, rd_valid});
        chk("reset levels", {6{8'hFF}}, channel_attenuation_level);
        @(posedge clk);
        rst <= 1'b0;
        exp_q.push_back({1'b1, 1'b1, mcb_pkg::IDX_ATT_FIRST, 8'hFF});
        host.send(1'b1, mcb_pkg::IDX_RDB, 8'h00);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            d8 = r[7:0] & 8'h3F;
            d9 = {2'b00, r[13:11], 3'(i)};
            da = {1'b0, r[16:15], 2'(i), 2'b00, r[17]};
            dc = r[31:24];
            wr(mcb_pkg::IDX_OUTSW, d8);
            wr(mcb_pkg::IDX_FCF, d9);
            wr(mcb_pkg::IDX_DEP, da);
            wr(mcb_pkg::IDX_AUX, dc);
            chk("output disable", 48'(d8[5:0]), 48'(channel_output_disable));
            chk("format", 48'(d9[2:0]), 48'(audio_format_select));
            chk("rolloff", 48'(d9[5]), 48'(rolloff_select));
            chk("deemph rate", 48'(da[4:3]), 48'(deemphasis_rate_select));
            chk("deemph enable", 48'(da[0]), 48'(deemphasis_enable_all));
            chk("phase", 48'(da[5]), 48'(output_phase_invert));
            chk("oversample", 48'(dc[7]), 48'(oversample_high));
            chk("pins", 48'(dc[6] ? dc[5:0] : {6{da[6]}}), 48'(shared_pins));
            chk("all zero", 48'(da[6]), 48'(all_zero_flag));
            rd1(mcb_pkg::IDX_OUTSW, d8);
            rd1(mcb_pkg::IDX_FCF, d9);
            rd1(mcb_pkg::IDX_DEP, da);
            rd1(mcb_pkg::IDX_AUX, dc);
        end
        rd1(mcb_pkg::IDX_RDB, {1'b0, mcb_pkg::IDX_RDB});
        wr(7'h0D, 8'h55);
        rd1(7'h0D, 8'h00);
        rd1(7'h00, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(mcb_pkg::IDX_FCF, k == 0 ? 8'h00 : (k == 1 ? 8'h10 : 8'h08));
            e = k == 0 ? 20 : (k == 1 ? 10 : 0);
            n = 0;
            prv = system_clock_out_pin;
            repeat (320) begin
                @(negedge clk);
                if (system_clock_out_pin === 1'b1 && prv === 1'b0)
                    n++;
                prv = system_clock_out_pin;
            end
            chk("clock out", 48'h1, 48'(n >= e - 1 && n <= e + 1
                && (k != 2 || system_clock_out_pin === 1'b0)));
        end
        wr(mcb_pkg::IDX_RDB, 8'h83);
        for (int j = 1; j <= 3; j++) begin
            exp_q.push_back({j == 3, 1'b1, 7'(j), 8'hFF});
            if (j == 1)
                host.send(1'b1, mcb_pkg::IDX_RDB, 8'h00);
            else
                host.step_read();
            repeat (2) @(posedge clk);
        end
        host.step_read();
        repeat (3) @(posedge clk);
        wr(mcb_pkg::IDX_RDB, 8'h01);
        wr(mcb_pkg::IDX_MUTE, 8'h01);
        wait_until(0, mcb_pkg::ATT_MUTE_CODE, 12000);
        repeat (300) @(negedge clk);
        chk("mute floor", 48'h80, 48'(channel_attenuation_level[7:0]));
        chk("other levels", {5{8'hFF}}, 48'(channel_attenuation_level[47:8]));
        chk("mute steps", 48'd127, 48'(n_steps));
        rd1(mcb_pkg::IDX_MUTE, 8'h01);
        wr(mcb_pkg::IDX_MUTE, 8'h00);
        wait_until(0, 8'hFF, 12000);
        // The step monitor runs on the same edge, so let it count the last step first.
        @(negedge clk);
        chk("unmute steps", 48'd254, 48'(n_steps));
        @(posedge clk);
        data_zero <= 6'h3F;
        wr(mcb_pkg::IDX_DEP, 8'h00);
        wr(mcb_pkg::IDX_AUX, 8'h00);
        repeat (8000) @(negedge clk);
        chk("flags early", 48'h0, 48'(shared_pins));
        wait_until(1, 8'h3F, 2000);
        chk("all zero set", 48'h1, 48'(all_zero_flag));
        wr(mcb_pkg::IDX_DEP, 8'h40);
        chk("flags inverted", 48'h0, 48'({all_zero_flag, shared_pins}));
        wr(mcb_pkg::IDX_AUX, 8'h6A);
        chk("aux pins", 48'h2A, 48'(shared_pins));
        @(posedge clk);
        data_zero <= 6'h3E;
        wr(mcb_pkg::IDX_AUX, 8'h00);
        repeat (40) @(negedge clk);
        chk("one flag clear", 48'h01, 48'(shared_pins));
        wr(mcb_pkg::IDX_AUX, 8'h80);
        chk("oversample set", 48'h1, 48'(oversample_high));
        wr(7'h02, 8'hFD);
        repeat (200) @(negedge clk);
        chk("ch2 target", 48'hFD, 48'(channel_attenuation_level[15:8]));
        rd1(7'h02, 8'hFD);
        chk("pending reads", 48'h0, 48'(exp_q.size()));
        close_out();
    end
endmodule
